// [src/usp_pkg.sv]
// constants for the four-mode serial port: register map, field positions,
// mode codes and bit-timing counts
// assumes a core clock of 25 MHz feeding the port directly
package usp_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] USP_ADDR_CONTROL = 8'h98;
    localparam logic [7:0] USP_ADDR_BUFFER  = 8'h99;
    localparam logic [7:0] USP_CONTROL_RST  = 8'h00;
    localparam logic [7:0] USP_READ_NONE    = 8'h00;

    localparam int unsigned USP_BIT_MODE_HI = 7;
    localparam int unsigned USP_BIT_MODE_LO = 6;
    localparam int unsigned USP_BIT_MP      = 5;
    localparam int unsigned USP_BIT_RX_EN   = 4;
    localparam int unsigned USP_BIT_TX9     = 3;
    localparam int unsigned USP_BIT_RX9     = 2;
    localparam int unsigned USP_BIT_TXF     = 1;
    localparam int unsigned USP_BIT_RXF     = 0;

    // ****************************************
    // modes
    // ****************************************
    localparam logic [1:0] USP_MODE_SHIFT = 2'h0;
    localparam logic [1:0] USP_MODE_VAR8  = 2'h1;
    localparam logic [1:0] USP_MODE_FIX9  = 2'h2;

    // ****************************************
    // timing
    // ****************************************
    localparam int         USP_CORE_HZ      = 25_000_000;
    localparam logic [3:0] USP_SHIFT_LAST   = 4'hB;
    localparam logic [3:0] USP_SHIFT_RISE   = 4'h6;
    localparam logic [1:0] USP_FIX_LAST_64  = 2'h3;
    localparam logic [1:0] USP_FIX_LAST_32  = 2'h1;
    localparam logic [3:0] USP_TICK_LAST    = 4'hF;
    localparam logic [3:0] USP_TICK_MID     = 4'h7;
    localparam logic [3:0] USP_M0_LAST_BIT  = 4'h7;
    localparam logic [3:0] USP_TX_STOP8     = 4'h9;
    localparam logic [3:0] USP_TX_STOP9     = 4'hA;
    localparam logic [3:0] USP_RX_LAST8     = 4'h8;
    localparam logic [3:0] USP_RX_LAST9     = 4'h9;

    localparam int USP_DATA_W     = 8;
    localparam int USP_FIFO_DEPTH = 16;

    typedef enum logic {USP_TX_IDLE, USP_TX_RUN} usp_tx_state_type;
    typedef enum logic [1:0] {USP_RX_IDLE, USP_RX_START, USP_RX_DATA} usp_rx_state_type;
endpackage

// [src/usp_serial_port.sv]
// four-mode serial port with transmit fifo
// assumes timer overflow pulses are one clock wide on clk_sys_in
// Behaviour
// - full duplex; receive buffer separate from shifter
// - buffer address: write transmits, read receives
// - two mode bits select one of four modes
// - 8-bit mode: multiproc needs valid stop bit
// - 9-bit modes: multiproc drops ninth bit zero
// - receive only while receive enable set
// - ninth bit sent from control; received latched
// - transmit flag: eighth bit end or stop start
// - receive flag: eighth bit end or mid-stop
// - shift mode: data on rxd, clock on txd
// - shift receive starts when enabled, flag clear
// - 8-bit frame: start, eight data, stop
// - 8-bit transmit: stop bit loaded ninth position
// - async receive starts on falling rxd edge
// - load buffer only if flag clear, filter passes
// - fixed 9-bit rate core/64 or core/32
// - 9-bit transmit starts on next rate tick
// - variable 9-bit mode uses timer rates
// - buffer write queues a byte; a full fifo drops it
// - 8-bit mode rate from timer overflows
// - timer b as rate source blocks its flag
// - timer a rate: overflow times 2^double over 32
// - timer b: sixteen overflows per bit
// - clock selects pick timer b per direction
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// fifo
// ****************************************
module usp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys_in,
    input  wire logic             reset_n_in,
    input  wire logic             ce_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_ready_out  = count_reg != (AW+1)'(DEPTH);
    assign out_valid_out = count_reg != '0;
    assign out_data_out  = mem_reg[rd_ptr_reg];
    assign push          = ce_in && in_valid_in && in_ready_out;
    assign pop           = ce_in && out_valid_out && out_ready_in;

    always_ff @(posedge clk_sys_in) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule // usp_fifo

// ****************************************
// serial port
// ****************************************
module usp_serial_port (
    input  wire logic       clk_sys_in,
    input  wire logic       reset_n_in,
    input  wire logic       ce_in,
    input  wire logic [7:0] sfr_addr_in,
    input  wire logic [7:0] sfr_wdata_in,
    input  wire logic       sfr_wr_in,
    input  wire logic       sfr_rd_in,
    output logic      [7:0] sfr_rdata_out,
    output logic            tx_fifo_ready_out,
    input  wire logic       rate_double_in,
    input  wire logic       tx_clock_select_in,
    input  wire logic       rx_clock_select_in,
    input  wire logic       timer_a_overflow_in,
    input  wire logic       timer_b_overflow_in,
    output logic            timer_b_overflow_block_out,
    input  wire logic       rxd_in,
    output logic            rxd_out,
    output logic            rxd_oe_n_out,
    output logic            txd_out,
    output logic            tx_done_flag_out,
    output logic            rx_done_flag_out
);
    import usp_pkg::*;

    logic [7:0]       ctl_reg;
    logic [7:0]       rx_buf_reg;
    logic [7:0]       rdata_reg;
    logic             rxd_meta_reg;
    logic             rxd_sync_reg;
    logic             rx_prev_reg;
    logic [1:0]       fix_cnt_reg;
    logic             t1_half_reg;
    usp_tx_state_type tx_state_reg;
    logic [10:0]      tx_shift_reg;
    logic [3:0]       tx_bit_reg;
    logic [3:0]       tx_sub_reg;
    logic [3:0]       m0_cnt_reg;
    logic             m0_rx_reg;
    logic             tx_wait_reg;
    logic             txd_reg;
    logic             txd_next;
    usp_rx_state_type rx_state_reg;
    logic [8:0]       rx_shift_reg;
    logic [3:0]       rx_bit_reg;
    logic [3:0]       rx_sub_reg;
    logic [1:0]       mode;
    logic             is_m0;
    logic             is_m1;
    logic             fix_tick;
    logic             t1_tick;
    logic             tx_tick;
    logic             rx_tick;
    logic             wr_ctl;
    logic             wr_buf;
    logic             fifo_valid;
    logic [7:0]       fifo_data;
    logic [3:0]       tx_stop;
    logic [3:0]       rx_last;
    logic             tx_set;
    logic             m0_rx_done;
    logic             rx_final;
    logic             ninth_v;
    logic [7:0]       data_v;
    logic             rx_accept;

    // ****************************************
    // decode and mode
    // ****************************************
    assign mode    = {ctl_reg[USP_BIT_MODE_HI], ctl_reg[USP_BIT_MODE_LO]};
    assign is_m0   = mode == USP_MODE_SHIFT;
    assign is_m1   = mode == USP_MODE_VAR8;
    assign wr_ctl  = ce_in && sfr_wr_in && sfr_addr_in == USP_ADDR_CONTROL;
    assign wr_buf  = ce_in && sfr_wr_in && sfr_addr_in == USP_ADDR_BUFFER;
    assign tx_stop = is_m1 ? USP_TX_STOP8 : USP_TX_STOP9;
    assign rx_last = is_m1 ? USP_RX_LAST8 : USP_RX_LAST9;

    // the fifo lets software queue bytes; a full fifo drops the write,
    // which shows on tx_fifo_ready_out
    usp_fifo #(
        .WIDTH (USP_DATA_W),
        .DEPTH (USP_FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_sys_in    (clk_sys_in),
        .reset_n_in    (reset_n_in),
        .ce_in         (ce_in),
        .in_valid_in   (wr_buf),
        .in_ready_out  (tx_fifo_ready_out),
        .in_data_in    (sfr_wdata_in),
        .out_valid_out (fifo_valid),
        .out_ready_in  (tx_state_reg == USP_TX_IDLE),
        .out_data_out  (fifo_data)
    );

    // ****************************************
    // rate ticks, sixteen per bit
    // ****************************************
    assign fix_tick = fix_cnt_reg == (rate_double_in ? USP_FIX_LAST_32 : USP_FIX_LAST_64);
    assign t1_tick  = timer_a_overflow_in && (rate_double_in || t1_half_reg);
    assign tx_tick  = mode == USP_MODE_FIX9 ? fix_tick :
                      (tx_clock_select_in ? timer_b_overflow_in : t1_tick);
    assign rx_tick  = mode == USP_MODE_FIX9 ? fix_tick :
                      (rx_clock_select_in ? timer_b_overflow_in : t1_tick);
    assign timer_b_overflow_block_out = tx_clock_select_in || rx_clock_select_in;

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            fix_cnt_reg <= '0;
            t1_half_reg <= 1'b0;
        end else if (ce_in) begin
            fix_cnt_reg <= fix_tick ? '0 : fix_cnt_reg + 1'b1;
            if (timer_a_overflow_in) begin
                t1_half_reg <= !t1_half_reg;
            end
        end
    end

    // ****************************************
    // pin synchroniser
    // ****************************************
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            rxd_meta_reg <= 1'b1;
            rxd_sync_reg <= 1'b1;
            rx_prev_reg  <= 1'b1;
        end else if (ce_in) begin
            rxd_meta_reg <= rxd_in;
            rxd_sync_reg <= rxd_meta_reg;
            rx_prev_reg  <= rxd_sync_reg;
        end
    end

    // ****************************************
    // transmitter, also runs shift-mode receive
    // ****************************************
    assign tx_set = ce_in && tx_state_reg == USP_TX_RUN &&
                    (is_m0 ? (!m0_rx_reg && m0_cnt_reg == USP_SHIFT_LAST &&
                              tx_bit_reg == USP_M0_LAST_BIT)
                           : (tx_tick && !tx_wait_reg && tx_sub_reg == USP_TICK_LAST &&
                              tx_bit_reg == tx_stop - 4'h1));
    assign m0_rx_done = ce_in && tx_state_reg == USP_TX_RUN && is_m0 && m0_rx_reg &&
                        m0_cnt_reg == USP_SHIFT_LAST && tx_bit_reg == USP_M0_LAST_BIT;

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            tx_state_reg <= USP_TX_IDLE;
            tx_shift_reg <= '1;
            tx_bit_reg   <= '0;
            tx_sub_reg   <= '0;
            m0_cnt_reg   <= '0;
            m0_rx_reg    <= 1'b0;
            tx_wait_reg  <= 1'b0;
        end else if (ce_in) begin
            case (tx_state_reg)
                USP_TX_IDLE: begin
                    tx_bit_reg <= '0;
                    tx_sub_reg <= '0;
                    m0_cnt_reg <= '0;
                    if (fifo_valid) begin
                        tx_state_reg <= USP_TX_RUN;
                        m0_rx_reg    <= 1'b0;
                        tx_wait_reg  <= !is_m0;
                        // stop bit sits in the ninth slot in 8-bit mode
                        tx_shift_reg <= is_m0 ? {3'h7, fifo_data} :
                            {1'b1, is_m1 ? 1'b1 : ctl_reg[USP_BIT_TX9], fifo_data, 1'b0};
                    end else if (is_m0 && ctl_reg[USP_BIT_RX_EN] && !ctl_reg[USP_BIT_RXF]) begin
                        tx_state_reg <= USP_TX_RUN;
                        m0_rx_reg    <= 1'b1;
                        tx_wait_reg  <= 1'b0;
                    end
                end
                USP_TX_RUN: begin
                    if (is_m0) begin
                        m0_cnt_reg <= m0_cnt_reg == USP_SHIFT_LAST ? '0 : m0_cnt_reg + 1'b1;
                        if (m0_rx_reg && m0_cnt_reg == USP_SHIFT_RISE) begin
                            tx_shift_reg[7:0] <= {rxd_sync_reg, tx_shift_reg[7:1]};
                        end
                        if (m0_cnt_reg == USP_SHIFT_LAST) begin
                            if (!m0_rx_reg) begin
                                tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                            end
                            tx_bit_reg <= tx_bit_reg + 1'b1;
                            if (tx_bit_reg == USP_M0_LAST_BIT) begin
                                tx_state_reg <= USP_TX_IDLE;
                            end
                        end
                    end else if (tx_tick) begin
                        if (tx_wait_reg) begin
                            tx_wait_reg <= 1'b0;
                        end else begin
                            tx_sub_reg <= tx_sub_reg + 1'b1;
                            if (tx_sub_reg == USP_TICK_LAST) begin
                                if (tx_bit_reg == tx_stop) begin
                                    tx_state_reg <= USP_TX_IDLE;
                                end else begin
                                    tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                                    tx_bit_reg   <= tx_bit_reg + 1'b1;
                                end
                            end
                        end
                    end
                end
                default: tx_state_reg <= USP_TX_IDLE;
            endcase
        end
    end

    // shift clock is low for the first half of each bit
    always_comb begin
        txd_next = 1'b1;
        if (tx_state_reg == USP_TX_RUN && is_m0) begin
            txd_next = m0_cnt_reg >= USP_SHIFT_RISE;
        end else if (tx_state_reg == USP_TX_RUN && !tx_wait_reg) begin
            txd_next = tx_shift_reg[0];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            txd_reg <= 1'b1;
        end else if (ce_in) begin
            txd_reg <= txd_next;
        end
    end

    assign txd_out      = txd_reg;
    assign rxd_out      = tx_shift_reg[0];
    assign rxd_oe_n_out = !(tx_state_reg == USP_TX_RUN && is_m0 && !m0_rx_reg);

    // ****************************************
    // asynchronous receiver
    // ****************************************
    assign rx_final = ce_in && rx_tick && rx_state_reg == USP_RX_DATA &&
                      rx_sub_reg == USP_TICK_MID && rx_bit_reg == rx_last;
    // in 8-bit mode the last sample is the stop bit and goes to the ninth field
    assign ninth_v  = is_m1 ? rxd_sync_reg : rx_shift_reg[8];
    assign data_v   = is_m1 ? rx_shift_reg[8:1] : rx_shift_reg[7:0];
    assign rx_accept = rx_final && !ctl_reg[USP_BIT_RXF] &&
                       (!ctl_reg[USP_BIT_MP] || ninth_v);

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            rx_state_reg <= USP_RX_IDLE;
            rx_shift_reg <= '0;
            rx_bit_reg   <= '0;
            rx_sub_reg   <= '0;
        end else if (ce_in) begin
            if (!ctl_reg[USP_BIT_RX_EN] || is_m0) begin
                rx_state_reg <= USP_RX_IDLE;
            end else begin
                case (rx_state_reg)
                    USP_RX_IDLE: begin
                        rx_sub_reg <= '0;
                        rx_bit_reg <= '0;
                        if (rx_prev_reg && !rxd_sync_reg) begin
                            rx_state_reg <= USP_RX_START;
                        end
                    end
                    USP_RX_START: begin
                        if (rx_tick) begin
                            rx_sub_reg <= rx_sub_reg + 1'b1;
                            // a glitch shorter than half a bit is not a start
                            if (rx_sub_reg == USP_TICK_MID) begin
                                rx_state_reg <= rxd_sync_reg ? USP_RX_IDLE : USP_RX_DATA;
                            end
                        end
                    end
                    USP_RX_DATA: begin
                        if (rx_tick) begin
                            rx_sub_reg <= rx_sub_reg + 1'b1;
                            if (rx_sub_reg == USP_TICK_MID) begin
                                if (rx_bit_reg == rx_last) begin
                                    rx_state_reg <= USP_RX_IDLE;
                                end else begin
                                    rx_shift_reg <= {rxd_sync_reg, rx_shift_reg[8:1]};
                                    rx_bit_reg   <= rx_bit_reg + 1'b1;
                                end
                            end
                        end
                    end
                    default: rx_state_reg <= USP_RX_IDLE;
                endcase
            end
        end
    end

    // receive buffer: the shifter keeps working while this holds a byte
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            rx_buf_reg <= '0;
        end else if (rx_accept) begin
            rx_buf_reg <= data_v;
        end else if (m0_rx_done) begin
            rx_buf_reg <= tx_shift_reg[7:0];
        end
    end

    // ****************************************
    // control register; hardware set beats software clear
    // ****************************************
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            ctl_reg <= USP_CONTROL_RST;
        end else if (ce_in) begin
            if (wr_ctl) begin
                ctl_reg <= sfr_wdata_in;
            end
            if (rx_accept) begin
                ctl_reg[USP_BIT_RX9] <= ninth_v;
            end
            if (tx_set) begin
                ctl_reg[USP_BIT_TXF] <= 1'b1;
            end
            if (rx_accept || m0_rx_done) begin
                ctl_reg[USP_BIT_RXF] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            rdata_reg <= USP_READ_NONE;
        end else if (ce_in && sfr_rd_in) begin
            rdata_reg <= sfr_addr_in == USP_ADDR_CONTROL ? ctl_reg :
                         sfr_addr_in == USP_ADDR_BUFFER ? rx_buf_reg : USP_READ_NONE;
        end
    end

    assign sfr_rdata_out    = rdata_reg;
    assign tx_done_flag_out = ctl_reg[USP_BIT_TXF];
    assign rx_done_flag_out = ctl_reg[USP_BIT_RXF];

    // ****************************************
    // assertions
    // ****************************************
    rx_flag_sticky_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        (ctl_reg[USP_BIT_RXF] && !wr_ctl) |=> ctl_reg[USP_BIT_RXF])
        else $error("receive flag cleared without a write");
    tx_flag_cause_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        $rose(ctl_reg[USP_BIT_TXF]) |-> $past(tx_set) || $past(wr_ctl))
        else $error("transmit flag rose without cause");
    reset_idle_a: assert property (@(posedge clk_sys_in)
        $past(!reset_n_in) |-> txd_out && !tx_done_flag_out && !rx_done_flag_out)
        else $error("not idle after reset");
    rx_full_drop_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        (rx_final && ctl_reg[USP_BIT_RXF]) |=> $stable(rx_buf_reg))
        else $error("buffer overwritten while flag set");
    mp_ninth_drop_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        (rx_final && !is_m1 && ctl_reg[USP_BIT_MP] && !rx_shift_reg[8] && !wr_ctl)
        |=> $stable(ctl_reg[USP_BIT_RXF]))
        else $error("multiproc filter let zero ninth bit through");
    rx_disable_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        (ce_in && !ctl_reg[USP_BIT_RX_EN]) |=> rx_state_reg == USP_RX_IDLE)
        else $error("receiver busy while disabled");
    shift_clock_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        (ce_in && tx_state_reg == USP_TX_RUN && is_m0 && m0_cnt_reg == USP_SHIFT_RISE)
        |=> txd_out)
        else $error("shift clock not high in second half of bit");
    start_bit_low_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        ($fell(tx_wait_reg) && tx_state_reg == USP_TX_RUN && !is_m0) |=> !txd_out)
        else $error("start bit not low");
endmodule // usp_serial_port

`default_nettype wire

// [sim/usp_remote_station.sv]
// far serial station: drives the receive line, decodes frames seen on txd
// the receive line idles high because this station drives it high
`timescale 1ns/1ps
`default_nettype none
module usp_remote_station (
    input  wire logic clk_sys_in,
    input  wire logic txd_in,
    output logic      line_out
);
    int         bit_clks = 32;
    int         n_frames = 0;
    logic [8:0] got_bits;

    // samples mid-bit, so a wrong bit rate shows up as corrupt data
    initial begin
        line_out = 1'b1;
        forever begin
            @(negedge txd_in);
            repeat (bit_clks / 2) @(posedge clk_sys_in);
            for (int i = 0; i < 9; i++) begin
                repeat (bit_clks) @(posedge clk_sys_in);
                got_bits[i] = txd_in;
            end
            n_frames++;
        end
    end

    // start bit, ten bits lsb first, then back to idle high
    task automatic send(input logic [9:0] bits);
        line_out = 1'b0;
        for (int i = 0; i < 11; i++) begin
            repeat (bit_clks) @(negedge clk_sys_in);
            line_out = (i < 10) ? bits[i] : 1'b1;
        end
        repeat (4) @(negedge clk_sys_in);
    endtask
endmodule // usp_remote_station
`default_nettype wire

// [sim/test_usp_serial_port.sv]
// bench for the four-mode serial port: register tasks plus far station
// assumes timer pulses made here: timer a every 2 clocks, timer b every 4
`timescale 1ns/1ps
`default_nettype none
module test_usp_serial_port;
    import usp_pkg::*;
    logic       clk, rst_n, wr, rd, tsel, rsel, ready, blk, rxd, rxd_o, oe_n, txd, txf, rxf;
    logic       line, ce, dbl;
    logic [7:0] addr, wdata, rdata, r, sh;
    logic [1:0] cnt = '0;
    int         n_fail = 0;
    int         tests_run = 0;
    int         n;
    assign rxd = oe_n ? line : rxd_o;
    usp_serial_port dut_u (.clk_sys_in(clk), .reset_n_in(rst_n), .ce_in(ce),
        .sfr_addr_in(addr), .sfr_wdata_in(wdata), .sfr_wr_in(wr), .sfr_rd_in(rd),
        .sfr_rdata_out(rdata), .tx_fifo_ready_out(ready), .rate_double_in(dbl),
        .tx_clock_select_in(tsel), .rx_clock_select_in(rsel), .timer_a_overflow_in(cnt[0]),
        .timer_b_overflow_in(&cnt), .timer_b_overflow_block_out(blk), .rxd_in(rxd),
        .rxd_out(rxd_o), .rxd_oe_n_out(oe_n), .txd_out(txd), .tx_done_flag_out(txf),
        .rx_done_flag_out(rxf));
    usp_remote_station peer_u (.clk_sys_in(clk), .txd_in(txd), .line_out(line));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(negedge clk) cnt <= cnt + 2'h1;
    // shift-mode data is stable on rxd at each rising shift clock
    always @(posedge txd)
        if (!oe_n) sh <= {rxd_o, sh[7:1]};
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {addr, wdata, wr} = {a, d, 1'b1};
        @(negedge clk);
        wr = 1'b0;
    endtask
    // extra cycle covers either reading of the read latency
    task automatic rd_reg(input logic [7:0] a);
        @(negedge clk);
        {addr, rd} = {a, 1'b1};
        @(negedge clk);
        rd = 1'b0;
        @(negedge clk);
        r = rdata;
    endtask
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_frames(input int k);
        n = peer_u.n_frames + k;
        for (int i = 0; i < 20000 && peer_u.n_frames < n; i++) @(posedge clk);
        repeat (40) @(negedge clk);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        {rst_n, addr, wdata, wr, rd, tsel, rsel} = '0;
        {ce, dbl} = 2'h3;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        rd_reg(USP_ADDR_CONTROL);
        chk(9'(r), 9'(USP_CONTROL_RST));
        chk(9'({blk, txd, txf, rxf}), 9'h4);
        wr_reg(USP_ADDR_CONTROL, 8'h98);
        wr_reg(USP_ADDR_BUFFER, 8'hA5);
        wait_frames(1);
        chk(peer_u.got_bits, 9'h1A5);
        chk(9'(txf), 9'h1);
        peer_u.send(10'h33C);
        peer_u.send(10'h377);
        rd_reg(USP_ADDR_CONTROL);
        chk(9'(r), 9'h9F);
        rd_reg(USP_ADDR_BUFFER);
        chk(9'(r), 9'h3C);
        $display("fixed rate test done");
        wr_reg(USP_ADDR_CONTROL, 8'hB0);
        peer_u.send(10'h211);
        chk(9'(rxf), 9'h0);
        peer_u.send(10'h322);
        rd_reg(USP_ADDR_BUFFER);
        chk(9'({rxf, r}), 9'h122);
        wr_reg(USP_ADDR_CONTROL, 8'h80);
        peer_u.send(10'h344);
        chk(9'(rxf), 9'h0);
        $display("filter test done");
        wr_reg(USP_ADDR_CONTROL, 8'h70);
        peer_u.send(10'h255);
        chk(9'(rxf), 9'h0);
        peer_u.send(10'h366);
        rd_reg(USP_ADDR_BUFFER);
        chk(9'({rxf, r}), 9'h166);
        wr_reg(USP_ADDR_BUFFER, 8'h5A);
        wait_frames(1);
        chk(peer_u.got_bits, 9'h15A);
        // timer b runs at half timer a's rate, so a wrong select shows
        {tsel, rsel, peer_u.bit_clks} = {1'b1, 1'b1, 32'd64};
        wr_reg(USP_ADDR_CONTROL, 8'hD8);
        chk(9'(blk), 9'h1);
        wr_reg(USP_ADDR_BUFFER, 8'hC3);
        wait_frames(1);
        chk(peer_u.got_bits, 9'h1C3);
        peer_u.send(10'h30F);
        rd_reg(USP_ADDR_BUFFER);
        chk(9'(r), 9'h0F);
        // core/64 from here on: rate double off
        {tsel, rsel, dbl, peer_u.bit_clks} = {1'b0, 1'b0, 1'b0, 32'd64};
        $display("timer rate test done");
        wr_reg(USP_ADDR_CONTROL, 8'h80);
        for (int i = 0; i < 17; i++) wr_reg(USP_ADDR_BUFFER, 8'(i));
        chk(9'(ready), 9'h0);
        wr_reg(USP_ADDR_BUFFER, 8'hEE);
        wait_frames(17);
        chk(peer_u.got_bits, 9'h010);
        chk(9'(ready), 9'h1);
        n = peer_u.n_frames;
        repeat (800) @(negedge clk);
        chk(9'(peer_u.n_frames - n), 9'h0);
        // a write while the clock enable is low must not land
        ce = 1'b0;
        wr_reg(USP_ADDR_CONTROL, 8'h5A);
        ce = 1'b1;
        rd_reg(USP_ADDR_CONTROL);
        chk(9'(r), 9'h82);
        $display("fifo test done");
        wr_reg(USP_ADDR_CONTROL, 8'h00);
        wr_reg(USP_ADDR_BUFFER, 8'h4B);
        repeat (3) @(negedge clk);
        chk(9'(oe_n), 9'h0);
        repeat (120) @(negedge clk);
        chk(9'(txf), 9'h1);
        chk(9'(sh), 9'h04B);
        // far side holds rxd low, so all-zero data proves the pin was read
        wr_reg(USP_ADDR_CONTROL, 8'h10);
        fork
            peer_u.send(10'h000);
        join_none
        repeat (120) @(negedge clk);
        rd_reg(USP_ADDR_BUFFER);
        chk(9'({rxf, r}), 9'h100);
        $display("shift test done");
        tally_and_finish();
    end
endmodule // test_usp_serial_port
`default_nettype wire
